// >>> verilog/conv_pkg.sv
// How it works
// - Comparator flag set on selected edge event
// - Comparator irq needs enable and global enable
// - Flag clears on vector or written one
// - Capture route gates comparator to timer capture
// - Mode: toggle, reserved, falling, rising
// - Mux enable, converter off: channel drives negative
// - Conversion yields ten bit code
// - Converter channel and reference selections apply only while converter enabled
// - Right justified default, left when adjust set
// - Low byte read blocks result updates
// - High byte read lifts result block
// - Completion flag set even when result discarded
// - Start bit reads one until completion; free run keeps it set
// - Channel change waits for conversion end
// - Free run converts back to back
// - Free run ignores converter flag state
// - Channel field offers ground and bandgap
// - Thirteen cycles, first after enable twenty-five
// - Completion writes result unless blocked, sets flag, clears start unless free run
// - Prescaler held reset while converter disabled
// - Comparator output synchronized, one-two cycle delay
package conv_pkg;
  // =====================================
  // Register offsets
  localparam logic [2:0] ADDR_CMP_CTRL  = 3'h0;
  localparam logic [2:0] ADDR_SPECIAL   = 3'h1;
  localparam logic [2:0] ADDR_CHAN_SEL  = 3'h2;
  localparam logic [2:0] ADDR_CONV_CTRL = 3'h3;
  localparam logic [2:0] ADDR_RES_LOW   = 3'h4;
  localparam logic [2:0] ADDR_RES_HIGH  = 3'h5;
  // =====================================
  // Bit positions
  localparam int BIT_CMP_OUT   = 5;
  localparam int BIT_CMP_FLAG  = 4;
  localparam int BIT_CMP_IE    = 3;
  localparam int BIT_CMP_CAP   = 2;
  localparam int BIT_MUX_EN    = 3;
  localparam int BIT_LEFT_ADJ  = 5;
  localparam int BIT_EN        = 7;
  localparam int BIT_START     = 6;
  localparam int BIT_FREE      = 5;
  localparam int BIT_CONV_FLAG = 4;
  localparam int BIT_CONV_IE   = 3;
  // =====================================
  // Reset values and timing
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [4:0] CYC_NORMAL     = 5'h0D;
  localparam logic [4:0] CYC_FIRST      = 5'h19;
  localparam logic [6:0] DIV_RESET      = 7'h00;
  // =====================================
  // Comparator modes
  localparam logic [1:0] MODE_TOGGLE    = 2'h0;
  localparam logic [1:0] MODE_FALL      = 2'h2;
  localparam logic [1:0] MODE_RISE      = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EDGE, ST_CONVERT} conv_state_t;
endpackage

// >>> verilog/conv_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface conv_sync_if;
  logic raw;
  logic synced;
  logic rise;
  logic fall;
  modport producer (input raw, output synced, output rise, output fall);
  modport consumer (output raw, input synced, input rise, input fall);
endinterface
`default_nettype wire

// >>> verilog/cmp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_sync (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Comparator level
  conv_sync_if.producer   s
);
  logic meta, stage, prev;
  logic next_meta, next_stage, next_prev;
  // =====================================
  // Two-flop synchroniser, then edge history
  always_comb begin
    next_meta  = s.raw;
    next_stage = meta;
    next_prev  = stage;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      meta  <= 1'b0;
      stage <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= next_meta;
      stage <= next_stage;
      prev  <= next_prev;
    end
  end
  assign s.synced = stage;
  // Only the second flop and its history feed edge logic
  assign s.rise = stage & ~prev;
  assign s.fall = ~stage & prev;
endmodule
`default_nettype wire

// >>> verilog/adc_comparator_control.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_comparator_control
  import conv_pkg::*;
#(
  parameter int DATA_W = 10
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [2:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [7:0]             rdata,
  // Cpu side
  input  wire logic              global_irq_enable,
  input  wire logic              cmp_vector_ack,
  input  wire logic              conv_vector_ack,
  output logic                   cmp_irq,
  output logic                   conv_irq,
  // Comparator analog side
  input  wire logic              cmp_result,
  output logic                   cmp_neg_use_mux,
  output logic [2:0]             cmp_neg_channel,
  output logic                   capture_in,
  // Converter analog side
  output logic [3:0]             conv_channel,
  output logic [1:0]             conv_reference,
  output logic                   conv_sample,
  input  wire logic [DATA_W-1:0] conv_code
);
  conv_sync_if sif ();
  logic [7:0] cmp_ctrl, special, chan_sel, conv_ctrl, res_low, res_high;
  logic [7:0] next_cmp_ctrl, next_special, next_chan_sel, next_conv_ctrl;
  logic [7:0] next_res_low, next_res_high;
  logic [3:0] act_channel, next_act_channel;
  logic [1:0] act_ref, next_act_ref;
  logic       blocked, next_blocked;
  logic       first_conv, next_first_conv;
  logic [6:0] div_cnt, next_div_cnt;
  logic [4:0] cyc, next_cyc;
  conv_state_t state, next_state;
  logic [7:0] next_rdata;
  logic       wr_cmp, wr_conv, wr_sel, tick, done, cmp_event;
  logic       en;

  assign sif.raw = cmp_result;
  cmp_sync u_sync (
    .clk (clk),
    .rst (rst),
    .s   (sif)
  );

  // =====================================
  // Decode
  assign wr_cmp  = wr && addr == ADDR_CMP_CTRL;
  assign wr_conv = wr && addr == ADDR_CONV_CTRL;
  assign wr_sel  = wr && addr == ADDR_CHAN_SEL;
  assign en      = conv_ctrl[BIT_EN];

  // =====================================
  // Comparator event decode
  always_comb begin
    case (cmp_ctrl[1:0])
      MODE_TOGGLE: cmp_event = sif.rise | sif.fall;
      MODE_FALL:   cmp_event = sif.fall;
      MODE_RISE:   cmp_event = sif.rise;
      default:     cmp_event = 1'b0;
    endcase
  end

  // =====================================
  // Comparator register
  always_comb begin
    next_cmp_ctrl = cmp_ctrl;
    if (wr_cmp) begin
      next_cmp_ctrl[3:0] = wdata[3:0];
      // Written one clears the flag
      next_cmp_ctrl[BIT_CMP_FLAG] = cmp_ctrl[BIT_CMP_FLAG] & ~wdata[BIT_CMP_FLAG];
    end
    if (cmp_vector_ack)
      next_cmp_ctrl[BIT_CMP_FLAG] = 1'b0;
    // Set beats a clear in the same cycle
    if (cmp_event)
      next_cmp_ctrl[BIT_CMP_FLAG] = 1'b1;
    next_cmp_ctrl[7:5] = 3'h0;
  end

  assign cmp_irq = cmp_ctrl[BIT_CMP_FLAG] & cmp_ctrl[BIT_CMP_IE] & global_irq_enable;
  assign capture_in = cmp_ctrl[BIT_CMP_CAP] & sif.synced;
  assign cmp_neg_use_mux = special[BIT_MUX_EN] & ~en;
  assign cmp_neg_channel = chan_sel[2:0];

  // =====================================
  // Prescaler: divide by 2^field, minimum 2
  always_comb begin
    next_div_cnt = en ? 7'(div_cnt + 7'h01) : DIV_RESET;
    case (conv_ctrl[2:0])
      3'h0, 3'h1: tick = en && div_cnt[0];
      3'h2: tick = en && &div_cnt[1:0];
      3'h3: tick = en && &div_cnt[2:0];
      3'h4: tick = en && &div_cnt[3:0];
      3'h5: tick = en && &div_cnt[4:0];
      3'h6: tick = en && &div_cnt[5:0];
      default: tick = en && &div_cnt[6:0];
    endcase
  end

  // =====================================
  // Conversion sequencer
  always_comb begin
    next_state      = state;
    next_cyc        = cyc;
    next_first_conv = first_conv;
    done            = 1'b0;
    if (!en) begin
      next_state      = ST_IDLE;
      next_first_conv = 1'b1;
    end else begin
      case (state)
        ST_IDLE:
          if (conv_ctrl[BIT_START]) next_state = ST_WAIT_EDGE;
        ST_WAIT_EDGE:
          if (tick) begin
            next_state = ST_CONVERT;
            next_cyc   = first_conv ? CYC_FIRST : CYC_NORMAL;
          end
        ST_CONVERT:
          if (tick) begin
            next_cyc = 5'(cyc - 5'h01);
            if (cyc == 5'h01) begin
              done            = 1'b1;
              next_first_conv = 1'b0;
              // Free run restarts at once, flag ignored
              if (conv_ctrl[BIT_FREE])
                next_cyc = CYC_NORMAL;
              else
                next_state = ST_IDLE;
            end
          end
        default: next_state = ST_IDLE;
      endcase
    end
  end
  assign conv_sample = state == ST_CONVERT;

  // =====================================
  // Converter control register
  always_comb begin
    next_conv_ctrl = conv_ctrl;
    if (wr_conv) begin
      next_conv_ctrl = wdata;
      next_conv_ctrl[BIT_START] = conv_ctrl[BIT_START] | wdata[BIT_START];
      next_conv_ctrl[BIT_CONV_FLAG] = conv_ctrl[BIT_CONV_FLAG] & ~wdata[BIT_CONV_FLAG];
      if (!wdata[BIT_EN])
        next_conv_ctrl[BIT_START] = 1'b0;
    end
    if (conv_vector_ack)
      next_conv_ctrl[BIT_CONV_FLAG] = 1'b0;
    if (done) begin
      next_conv_ctrl[BIT_CONV_FLAG] = 1'b1;
      if (!conv_ctrl[BIT_FREE])
        next_conv_ctrl[BIT_START] = 1'b0;
    end
  end
  assign conv_irq = conv_ctrl[BIT_CONV_FLAG] & conv_ctrl[BIT_CONV_IE] & global_irq_enable;

  // =====================================
  // Selections, latched while safe
  always_comb begin
    next_chan_sel    = wr_sel ? wdata : chan_sel;
    next_special     = (wr && addr == ADDR_SPECIAL) ? (wdata & 8'h08) : special;
    next_act_channel = act_channel;
    next_act_ref     = act_ref;
    // Live only when enabled and not mid conversion
    if (en && (state != ST_CONVERT || done)) begin
      next_act_channel = chan_sel[3:0];
      next_act_ref     = chan_sel[7:6];
    end
  end
  assign conv_channel   = act_channel;
  assign conv_reference = act_ref;

  // =====================================
  // Result registers and lock
  always_comb begin
    next_res_low  = res_low;
    next_res_high = res_high;
    next_blocked  = blocked;
    if (rd && addr == ADDR_RES_LOW)  next_blocked = 1'b1;
    if (rd && addr == ADDR_RES_HIGH) next_blocked = 1'b0;
    if (done && !blocked) begin
      if (chan_sel[BIT_LEFT_ADJ]) begin
        next_res_high = conv_code[9:2];
        next_res_low  = {conv_code[1:0], 6'h00};
      end else begin
        next_res_high = {6'h00, conv_code[9:8]};
        next_res_low  = conv_code[7:0];
      end
    end
  end

  // =====================================
  // Read mux
  always_comb begin
    next_rdata = 8'h00;
    if (!rd) next_rdata = 8'h00;
    else if (addr == ADDR_CMP_CTRL)  next_rdata = {2'h0, sif.synced, cmp_ctrl[4:0]};
    else if (addr == ADDR_SPECIAL)   next_rdata = special;
    else if (addr == ADDR_CHAN_SEL)  next_rdata = chan_sel;
    else if (addr == ADDR_CONV_CTRL) next_rdata = conv_ctrl;
    else if (addr == ADDR_RES_LOW)   next_rdata = res_low;
    else if (addr == ADDR_RES_HIGH)  next_rdata = res_high;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_ctrl    <= RESET_BYTE;
      special     <= RESET_BYTE;
      chan_sel    <= RESET_BYTE;
      conv_ctrl   <= RESET_BYTE;
      res_low     <= RESET_BYTE;
      res_high    <= RESET_BYTE;
      act_channel <= 4'h0;
      act_ref     <= 2'h0;
      blocked     <= 1'b0;
      first_conv  <= 1'b1;
      div_cnt     <= DIV_RESET;
      cyc         <= 5'h00;
      state       <= ST_IDLE;
      rdata       <= 8'h00;
    end else begin
      cmp_ctrl    <= next_cmp_ctrl;
      special     <= next_special;
      chan_sel    <= next_chan_sel;
      conv_ctrl   <= next_conv_ctrl;
      res_low     <= next_res_low;
      res_high    <= next_res_high;
      act_channel <= next_act_channel;
      act_ref     <= next_act_ref;
      blocked     <= next_blocked;
      first_conv  <= next_first_conv;
      div_cnt     <= next_div_cnt;
      cyc         <= next_cyc;
      state       <= next_state;
      rdata       <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// >>> dv/adc_cmp_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_cmp_asserts
  import conv_pkg::*;
(
  // Clock, reset, bus
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  // Cpu side
  input wire logic       global_irq_enable,
  input wire logic       cmp_vector_ack,
  input wire logic       cmp_irq,
  // Analog side
  input wire logic       cmp_result,
  input wire logic       cmp_neg_use_mux,
  input wire logic [2:0] cmp_neg_channel,
  input wire logic       capture_in,
  input wire logic [3:0] conv_channel,
  input wire logic [1:0] conv_reference,
  input wire logic       conv_sample
);
  // ====
  // Register shadows from bus writes, comparator history and sample length
  logic       en, mux, cap, ie;
  logic [1:0] mode;
  logic [2:0] chl;
  logic [5:0] hist;
  logic [7:0] slen;
  logic       quiet;
  // Six quiet samples: no comparator event can still be in flight
  assign quiet = (hist == {6{cmp_result}});
  always_ff @(posedge clk) begin
    if (rst) begin
      {en, mux, cap, ie, mode, chl, hist, slen} <= '0;
    end else begin
      hist <= {hist[4:0], cmp_result};
      slen <= conv_sample ? slen + 8'h01 : 8'h00;
      if (wr && addr == ADDR_CMP_CTRL) {ie, cap, mode} <= wdata[3:0];
      if (wr && addr == ADDR_SPECIAL) mux <= wdata[BIT_MUX_EN];
      if (wr && addr == ADDR_CHAN_SEL) chl <= wdata[2:0];
      if (wr && addr == ADDR_CONV_CTRL) en <= wdata[BIT_EN];
    end
  end
  // ====
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_cap_off: assert property (!cap |-> !capture_in)
    else $error("capture without route");
  a_cap_follow: assert property (cap && quiet |-> capture_in == cmp_result)
    else $error("capture differs from comparator");
  a_cmp_gate: assert property (cmp_irq |-> ie && global_irq_enable)
    else $error("comparator irq not gated");
  a_neg_mux: assert property (cmp_neg_use_mux == (mux && !en))
    else $error("negative input choice wrong");
  a_neg_chan: assert property (cmp_neg_use_mux |-> cmp_neg_channel == chl)
    else $error("negative channel wrong");
  a_sel_hold: assert property (!en && !$past(en) |-> $stable({conv_channel, conv_reference}))
    else $error("selection applied while disabled");
  a_toggle_evt: assert property (ie && global_irq_enable && mode == MODE_TOGGLE
    && $changed(cmp_result) |-> ##[2:5] cmp_irq)
    else $error("toggle event missed");
  a_rise_evt: assert property (ie && global_irq_enable && mode == MODE_RISE
    && $rose(cmp_result) |-> ##[2:5] cmp_irq)
    else $error("rising event missed");
  a_mode_rsvd: assert property (mode == 2'h1 && !cmp_irq |=> !cmp_irq)
    else $error("reserved mode raised irq");
  a_flag_clr: assert property ((cmp_vector_ack || (wr && addr == ADDR_CMP_CTRL
    && wdata[BIT_CMP_FLAG])) && quiet |=> !cmp_irq)
    else $error("comparator flag not cleared");
  a_conv_len: assert property ($fell(conv_sample) |-> slen >= 8'h1A)
    else $error("conversion too short");
  c_capture: cover property (capture_in);
  c_conv_end: cover property ($fell(conv_sample));
  c_vec_ack: cover property (cmp_vector_ack && cmp_irq);
endmodule
`default_nettype wire

// >>> dv/analog_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
  // Clock
  input wire logic       clk,
  // Converter side
  input wire logic [3:0] conv_channel,
  input wire logic       conv_sample,
  output logic     [9:0] conv_code,
  // Comparator side
  input wire logic       cmp_drive,
  output logic           cmp_result
);
  // ====
  // Behaviour
  logic       held;
  logic [9:0] level;
  // Channel 15 is grounded, others give a channel-marked code
  assign level = (conv_channel == 4'hF) ? 10'h000 : {conv_channel, 6'h15};
  // Code goes stale one cycle after the conversion window
  always_ff @(posedge clk) held <= conv_sample;
  assign conv_code = (conv_sample || held) ? level : ~level;
  assign cmp_result = cmp_drive;
endmodule
`default_nettype wire

// >>> dv/adc_comparator_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_comparator_control_bench;
  import conv_pkg::*;
  // ====
  // Wiring
  logic        clk, rst, wr, rd, cmp_drive, rd_q;
  logic        global_irq_enable, cmp_vector_ack, conv_vector_ack;
  logic        cmp_irq, conv_irq, cmp_result, cmp_neg_use_mux, capture_in, conv_sample;
  logic [2:0]  addr, cmp_neg_channel;
  logic [7:0]  wdata, rdata;
  logic [3:0]  conv_channel;
  logic [1:0]  conv_reference;
  logic [9:0]  conv_code;
  logic [15:0] ev;
  logic [15:0] expq[$];
  int          n_errors = 0, cmp_count = 0, n_high = 0, n0;
  adc_comparator_control dut (
    .clk               (clk),
    .rst               (rst),
    .addr              (addr),
    .wdata             (wdata),
    .wr                (wr),
    .rd                (rd),
    .rdata             (rdata),
    .global_irq_enable (global_irq_enable),
    .cmp_vector_ack    (cmp_vector_ack),
    .conv_vector_ack   (conv_vector_ack),
    .cmp_irq           (cmp_irq),
    .conv_irq          (conv_irq),
    .cmp_result        (cmp_result),
    .cmp_neg_use_mux   (cmp_neg_use_mux),
    .cmp_neg_channel   (cmp_neg_channel),
    .capture_in        (capture_in),
    .conv_channel      (conv_channel),
    .conv_reference    (conv_reference),
    .conv_sample       (conv_sample),
    .conv_code         (conv_code)
  );
  analog_core_model model (
    .clk               (clk),
    .conv_channel      (conv_channel),
    .conv_sample       (conv_sample),
    .conv_code         (conv_code),
    .cmp_drive         (cmp_drive),
    .cmp_result        (cmp_result)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ====
  // Bus tasks and checking
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // Mask 0 marks a poll whose value is not compared
  task automatic rreg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    expq.push_back({m, e & m});
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 100; i++) begin
      rreg(ADDR_CONV_CTRL, 8'h00, 8'h00);
      idle(1);
      if (rdata[BIT_START] === 1'b0) return;
    end
    // A conversion that never ends is a failure
    n_errors++;
  endtask
  task automatic conv(input logic [3:0] ch, input logic la, input logic [7:0] len);
    logic [9:0] c;
    int         h0;
    c = (ch == 4'hF) ? 10'h000 : {ch, 6'h15};
    h0 = n_high;
    wreg(ADDR_CHAN_SEL, {2'b01, la, 1'b0, ch});
    // Flag cleared by the start write, so completion must set it again
    wreg(ADDR_CONV_CTRL, 8'hD8);
    idle(6);
    wreg(ADDR_CHAN_SEL, {2'b01, la, 5'h0E});
    rreg(ADDR_CONV_CTRL, 8'h40, 8'h40);
    chk({4'h0, conv_channel}, {4'h0, ch});
    wait_done;
    chk(8'(n_high - h0), len);
    chk({6'h00, conv_reference}, 8'h01);
    rreg(ADDR_CONV_CTRL, 8'h10, 8'h50);
    rreg(ADDR_RES_LOW, la ? {c[1:0], 6'h00} : c[7:0], 8'hFF);
    rreg(ADDR_RES_HIGH, la ? c[9:2] : {6'h00, c[9:8]}, 8'hFF);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ====
  // Read-back monitor and conversion counter
  always @(posedge clk) begin
    if (rd_q === 1'b1) begin
      ev = expq.pop_front();
      if (ev[15:8] !== 8'h00) chk(rdata & ev[15:8], ev[7:0]);
    end
    rd_q <= rd;
    // Sampling cycles; back to back conversions keep this rising
    if (conv_sample === 1'b1) n_high++;
  end
  initial begin
    #25000;
    n_errors++;
    give_verdict;
  end
  // ====
  // Scenarios
  initial begin
    {rst, wr, rd, cmp_drive, global_irq_enable, cmp_vector_ack, conv_vector_ack} = 7'h40;
    addr = 3'h0;
    wdata = 8'h00;
    void'($urandom(32'h5E35));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wreg(3'h7, 8'hFF);
    for (int a = 0; a < 8; a++) rreg(3'(a), 8'h00, 8'hFF);
    global_irq_enable <= 1'b1;
    // Irq enable dropped around every mode change
    for (int m = 0; m < 4; m++) begin
      wreg(ADDR_CMP_CTRL, {6'h04, 2'(m)});
      wreg(ADDR_CMP_CTRL, {6'h06, 2'(m)});
      cmp_drive <= 1'b1;
      idle(8);
      rreg(ADDR_CMP_CTRL, {2'b00, 1'b1, m == 0 || m == 3, 4'h0}, 8'h30);
      cmp_vector_ack <= (m == 0);
      idle(1);
      cmp_vector_ack <= 1'b0;
      wreg(ADDR_CMP_CTRL, {6'h06, 2'(m)});
      cmp_drive <= 1'b0;
      idle(8);
      rreg(ADDR_CMP_CTRL, {3'b000, m == 0 || m == 2, 4'h0}, 8'h30);
    end
    wreg(ADDR_CMP_CTRL, 8'h04);
    wreg(ADDR_SPECIAL, 8'h08);
    wreg(ADDR_CHAN_SEL, 8'h05);
    repeat (4) begin
      cmp_drive <= ~cmp_drive;
      global_irq_enable <= 1'($urandom);
      idle(8);
    end
    global_irq_enable <= 1'b1;
    chk({4'h0, conv_channel}, 8'h00);
    // Divider field 0 ticks every second clock
    conv(4'($urandom_range(14)), 1'b0, 8'(2 * CYC_FIRST));
    conv(4'hF, 1'b1, 8'(2 * CYC_NORMAL));
    // Low byte read blocks the pair; the next result is lost
    rreg(ADDR_RES_LOW, 8'h00, 8'h00);
    wreg(ADDR_CONV_CTRL, 8'hD8);
    wait_done;
    rreg(ADDR_CONV_CTRL, 8'h10, 8'h10);
    rreg(ADDR_RES_HIGH, 8'h00, 8'hFF);
    n0 = n_high;
    // Divider field 2: one tick every fourth clock
    wreg(ADDR_CONV_CTRL, 8'hEA);
    idle(160);
    rreg(ADDR_CONV_CTRL, 8'h50, 8'h50);
    rreg(ADDR_RES_LOW, 8'h40, 8'hFF);
    rreg(ADDR_RES_HIGH, 8'hE5, 8'hFF);
    chk({7'h00, conv_irq}, 8'h01);
    conv_vector_ack <= 1'b1;
    wreg(ADDR_CONV_CTRL, 8'h00);
    conv_vector_ack <= 1'b0;
    idle(4);
    chk({7'h00, n_high - n0 > 104}, 8'h01);
    give_verdict;
  end
endmodule
bind adc_comparator_control adc_cmp_asserts checks (
  .clk               (clk),
  .rst               (rst),
  .addr              (addr),
  .wdata             (wdata),
  .wr                (wr),
  .global_irq_enable (global_irq_enable),
  .cmp_vector_ack    (cmp_vector_ack),
  .cmp_irq           (cmp_irq),
  .cmp_result        (cmp_result),
  .cmp_neg_use_mux   (cmp_neg_use_mux),
  .cmp_neg_channel   (cmp_neg_channel),
  .capture_in        (capture_in),
  .conv_channel      (conv_channel),
  .conv_reference    (conv_reference),
  .conv_sample       (conv_sample)
);
`default_nettype wire
